// File: logic/io_expander.sv
/*
 file: two-wire slave, register pairs and change interrupt of a 16-bit port expander.
 assumes: bus lines and port pins are asynchronous and resolved by the bench from the
 output enables; clk_i is fast enough (10 MHz) to oversample the bus clock.
*/
`include "io_expander_cfg.svh"
//Contract
//- input pin edge raises interrupt
//- clear on level return or port read
//- read clear at ack clock rise
//- later changes raise interrupt again
//- output pins never interrupt
//- direction change may give false interrupt
//- interrupt is open drain, low active
//- write address then command byte
//- command byte selects register
//- writes alternate within register pair
//- unlimited data bytes per write
//- read via restart with read bit
//- read data captured at ack rise
//- further read bytes alternate in pair
//- pointer continues in pair after restart
//- stop keeps last acknowledged output data
//- direct read uses previous pointer
//- reset loads all defaults
//- direction one input, zero output
//- input registers follow pins, ignore writes
//- polarity bit inverts reported input
//- output reads return written value
module io_expander
    import io_expander_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      reset_i,
    input  wire io_expander_pkg::bus_pins_s bus_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    output logic                           int_n_o,
    output logic                           int_n_oe_o,
    input  wire logic [15:0]               port_i,
    output logic      [15:0]               port_o,
    output logic      [15:0]               port_oe_o
);
    import io_expander_pkg::*;

    logic [1:0]  bus_s;
    logic [15:0] pin_s;
    logic        scl_d_reg;
    logic        sda_d_reg;
    bus_state_e  state_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  shift_reg;
    logic [2:0]  ptr_reg;
    logic [7:0]  tx_reg;
    logic        rd_reg;
    regs_s       regs_reg;
    logic [15:0] snap_reg;
    logic        int_reg;
    logic        ack_rd_reg;
    logic        full_reg;
    logic        ack_cmd_reg;
    logic        ack_data_reg;

    pin_sync #(.WIDTH(2), .INIT(16'hFFFF)) u_bus_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     ({bus_i.scl, bus_i.sda}),
        .q_o     (bus_s)
    );
    // pins start at the snapshot reset value, so no false change right after reset
    pin_sync #(.WIDTH(16), .INIT(16'h0000)) u_pin_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .d_i     (port_i),
        .q_o     (pin_s)
    );

    wire scl = bus_s[1];
    wire sda = bus_s[0];
    wire scl_rise = scl && !scl_d_reg;
    wire scl_fall = !scl && scl_d_reg;
    wire start_c  = scl && scl_d_reg && sda_d_reg && !sda;
    wire stop_c   = scl && scl_d_reg && !sda_d_reg && sda;

    // polarity-corrected input value, independent of direction
    wire [15:0] in_val = pin_s ^ {regs_reg.pol1, regs_reg.pol0};
    wire [15:0] is_in  = {regs_reg.dir1, regs_reg.dir0};

    function automatic logic [7:0] reg_read(input logic [2:0] p, input regs_s r, input logic [15:0] iv);
        case (p)
            `REG_IN0:  reg_read = iv[7:0];
            `REG_IN1:  reg_read = iv[15:8];
            `REG_OUT0: reg_read = r.out0;
            `REG_OUT1: reg_read = r.out1;
            `REG_POL0: reg_read = r.pol0;
            `REG_POL1: reg_read = r.pol1;
            `REG_DIR0: reg_read = r.dir0;
            default:   reg_read = r.dir1;
        endcase
    endfunction : reg_read

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
        end
    end

    // bus state machine; start seen any time, so a busy-bus start is just a restart
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg    <= ST_IDLE;
            bit_reg      <= 3'h0;
            shift_reg    <= 8'h00;
            rd_reg       <= 1'b0;
            full_reg     <= 1'b0;
            ack_cmd_reg  <= 1'b0;
            ack_data_reg <= 1'b0;
        end else if (stop_c) begin
            state_reg <= ST_IDLE;
        end else if (start_c) begin
            state_reg <= ST_ADDR;
            bit_reg   <= 3'h0;
            full_reg  <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda};
                        bit_reg   <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            full_reg <= 1'b1;
                        end
                    end
                    // bit counter wraps to zero, so a flag marks eight bits taken
                    if (scl_fall && full_reg) begin
                        full_reg     <= 1'b0;
                        ack_cmd_reg  <= state_reg == ST_CMD;
                        ack_data_reg <= state_reg == ST_WDATA;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == `SLAVE_ADDR) begin
                                rd_reg    <= shift_reg[0] == `READ_BIT;
                                state_reg <= ST_ACK;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end else begin
                            rd_reg    <= 1'b0;
                            state_reg <= ST_ACK;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_reg   <= 3'h0;
                        state_reg <= rd_reg ? ST_RDATA : ((ack_cmd_reg || ack_data_reg) ? ST_WDATA : ST_CMD);
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            state_reg <= ST_RACK;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state_reg <= sda ? ST_IGNORE : ST_RACK;
                    end else if (scl_fall) begin
                        bit_reg   <= 3'h0;
                        state_reg <= ST_RDATA;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // marks that the command byte has been taken in this transfer
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ack_rd_reg <= 1'b0;
        end else if (start_c || stop_c) begin
            ack_rd_reg <= 1'b0;
        end else if (state_reg == ST_ACK && scl_fall && !rd_reg && ack_cmd_reg) begin
            ack_rd_reg <= 1'b1;
        end
    end

    // pointer and register writes, taken at the ack edge of each byte
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ptr_reg  <= `PTR_RESET;
            regs_reg <= {`OUT_RESET, `OUT_RESET, `POL_RESET, `POL_RESET, `DIR_RESET, `DIR_RESET};
        end else if (state_reg == ST_ACK && scl_fall && !rd_reg) begin
            if (ack_cmd_reg) begin
                ptr_reg <= shift_reg[2:0];
            end else if (ack_data_reg) begin
                case (ptr_reg)
                    `REG_OUT0: regs_reg.out0 <= shift_reg;
                    `REG_OUT1: regs_reg.out1 <= shift_reg;
                    `REG_POL0: regs_reg.pol0 <= shift_reg;
                    `REG_POL1: regs_reg.pol1 <= shift_reg;
                    `REG_DIR0: regs_reg.dir0 <= shift_reg;
                    `REG_DIR1: regs_reg.dir1 <= shift_reg;
                    default: begin
                    end
                endcase
                ptr_reg <= {ptr_reg[2:1], ~ptr_reg[0]};
            end
        end else if (state_reg == ST_RACK && scl_rise) begin
            ptr_reg <= {ptr_reg[2:1], ~ptr_reg[0]};
        end
    end

    // read byte loaded at the ack rise before it goes out
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            tx_reg <= 8'hFF;
        end else if ((state_reg == ST_ACK && rd_reg && scl_rise) || (state_reg == ST_RACK && scl_rise)) begin
            tx_reg <= reg_read(state_reg == ST_RACK ? {ptr_reg[2:1], ~ptr_reg[0]} : ptr_reg,
                               regs_reg, in_val);
        end else if (state_reg == ST_RDATA && scl_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b1};
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
            if (state_reg == ST_ACK) begin
                sda_oe_o <= 1'b1;
            end else if (state_reg == ST_RDATA) begin
                sda_oe_o <= !tx_reg[7];
            end else begin
                sda_oe_o <= 1'b0;
            end
        end
    end

    // change snapshot: read clear reloads it, so later edges retrigger
    wire       rd_clear = (state_reg == ST_RACK || (state_reg == ST_ACK && rd_reg)) && scl_rise;
    wire       rd_port  = rd_clear && ptr_reg[2:1] == 2'b00 && !(state_reg == ST_ACK && 1'b0);
    wire [15:0] diff    = (in_val ^ snap_reg) & is_in;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            snap_reg <= 16'h0000;
            int_reg  <= 1'b0;
        end else begin
            if (rd_port) begin
                snap_reg <= in_val;
                int_reg  <= 1'b0;
            end else begin
                int_reg  <= |diff;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            int_n_o    <= 1'b0;
            int_n_oe_o <= 1'b0;
        end else begin
            int_n_o    <= 1'b0;
            int_n_oe_o <= int_reg;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_o    <= 16'hFFFF;
            port_oe_o <= 16'h0000;
        end else begin
            port_o    <= {regs_reg.out1, regs_reg.out0};
            port_oe_o <= ~is_in;
        end
    end

    chk_dir_out_reset: assert property (@(posedge clk_i) $fell(reset_i) |-> port_oe_o == 16'h0000)
        else $error("port enables not cleared by reset");
    chk_out_no_int: assert property (@(posedge clk_i) disable iff (reset_i)
        (diff == 16'h0000) |=> !int_reg)
        else $error("output pin raised interrupt");
    chk_int_rise: assert property (@(posedge clk_i) disable iff (reset_i)
        (|diff && !rd_port) |=> int_reg ##1 int_n_oe_o)
        else $error("change did not raise interrupt");
    chk_read_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        rd_port |=> !int_reg)
        else $error("read did not clear interrupt");
    chk_int_open_drain: assert property (@(posedge clk_i) disable iff (reset_i) !int_n_o)
        else $error("interrupt pin driven high");
    chk_pair_toggle: assert property (@(posedge clk_i) disable iff (reset_i)
        (state_reg == ST_RACK && scl_rise && !stop_c && !start_c) |=>
        ptr_reg == {$past(ptr_reg[2:1]), ~$past(ptr_reg[0])})
        else $error("read pointer did not alternate");
    chk_pair_same: assert property (@(posedge clk_i) disable iff (reset_i)
        (ack_rd_reg && !start_c) |=> ptr_reg[2:1] == $past(ptr_reg[2:1]))
        else $error("pointer left its pair");
    chk_port_follow: assert property (@(posedge clk_i) disable iff (reset_i)
        ##1 1'b1 |-> port_o == $past({regs_reg.out1, regs_reg.out0}))
        else $error("port outputs differ from stored value");
endmodule : io_expander

// File: logic/io_expander_cfg.svh
/*
 file: constants for the two-wire port expander (register indices, resets, slave address and read bit).
 assumes: included by the package, the expander module and the bench by bare name.
*/
`ifndef IO_EXPANDER_CFG_SVH
`define IO_EXPANDER_CFG_SVH
`define REG_IN0      3'h0
`define REG_IN1      3'h1
`define REG_OUT0     3'h2
`define REG_OUT1     3'h3
`define REG_POL0     3'h4
`define REG_POL1     3'h5
`define REG_DIR0     3'h6
`define REG_DIR1     3'h7
`define OUT_RESET    8'hFF
`define POL_RESET    8'h00
`define DIR_RESET    8'hFF
`define PTR_RESET    3'h0
`define SLAVE_ADDR   7'h20
`define READ_BIT     1'b1
`endif

// File: logic/io_expander_pkg.sv
/*
 file: shared types for the port expander.
 assumes: constants come from io_expander_cfg.svh.
*/
`include "io_expander_cfg.svh"
package io_expander_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_WDATA,
        ST_RDATA,
        ST_ACK,
        ST_RACK,
        ST_IGNORE
    } bus_state_e;

    typedef struct packed {
        logic [7:0] out0;
        logic [7:0] out1;
        logic [7:0] pol0;
        logic [7:0] pol1;
        logic [7:0] dir0;
        logic [7:0] dir1;
    } regs_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_s;
endpackage : io_expander_pkg

// File: logic/pin_sync.sv
/*
 file: two-flop synchroniser for a vector of pins.
 assumes: single clock, asynchronous active-high reset.
*/
module pin_sync #(
    parameter int          WIDTH = 2,
    parameter logic [15:0] INIT  = 16'hFFFF
) (
    input  wire logic             clk_i,
    input  wire logic             reset_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta_reg <= INIT[WIDTH-1:0];
            q_o      <= INIT[WIDTH-1:0];
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : pin_sync

// File: tb/i2c_master.sv
/*
 file: behavioural two-wire bus master driving the expander's bus pins.
 assumes: bench resolves sda from all enables with a pull-up; scl is master-only.
*/
module i2c_master (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle: both lines released, scl stands still between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // quarter bit: 2 clocks, so an 800 ns bus clock period
    task q;
        repeat (2) @(negedge clk_i);
    endtask : q

    // start or restart, only entered from idle or after a full byte
    task start;
        q;
        sda_o = 1'b1;
        q;
        scl_o = 1'b1;
        q;
        sda_o = 1'b0;
        q;
        scl_o = 1'b0;
    endtask : start

    // stop may end a frame at any byte boundary
    task stop;
        q;
        sda_o = 1'b0;
        q;
        scl_o = 1'b1;
        q;
        sda_o = 1'b1;
        q;
    endtask : stop

    // data held through the whole high phase; sampled mid-high
    task bit_io(input logic b, output logic rb);
        q;
        sda_o = b;
        q;
        scl_o = 1'b1;
        q;
        rb = sda_i;
        q;
        scl_o = 1'b0;
    endtask : bit_io

    // msb first; ack_in 1 releases the line, 0 acknowledges a read
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] rd, output logic ack);
        logic ab;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], rd[i]);
        end
        bit_io(ack_in, ab);
        ack = ~ab;
    endtask : xfer
endmodule : i2c_master

// File: tb/tb_io_expander.sv
/*
 file: self-checking bench for the port expander, bus-level register tasks.
 assumes: pull-ups on sda and interrupt line; pins resolved from port enables.
*/
`include "io_expander_cfg.svh"
module tb_io_expander
    import io_expander_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        m_scl, m_sda, sda_o, sda_oe, int_n, int_oe, sda_l, int_l, a;
    logic [7:0]  r;
    logic [15:0] ext = 16'h0000;
    logic [15:0] pins, port_o, port_oe, ev;
    bus_pins_s   bus;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;

    assign sda_l = m_sda & (sda_oe ? sda_o : 1'b1);
    assign int_l = int_oe ? int_n : 1'b1;
    assign pins  = (port_oe & port_o) | (~port_oe & ext);
    assign bus   = '{scl: m_scl, sda: sda_l};

    always #50 clk = ~clk;

    io_expander io_expander_i (.clk_i(clk), .reset_i(rst), .bus_i(bus), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .int_n_o(int_n), .int_n_oe_o(int_oe), .port_i(pins), .port_o(port_o), .port_oe_o(port_oe));
    i2c_master i2c_master_i (.clk_i(clk), .sda_i(sda_l), .scl_o(m_scl), .sda_o(m_sda));

    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // generous ceiling, the run needs about 3700 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 12000) begin
            fails++;
            print_verdict;
        end
    end

    task check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task adr(input logic rw);
        i2c_master_i.start;
        i2c_master_i.xfer({`SLAVE_ADDR, rw}, 1'b1, r, a);
        check({15'h0000, a}, 16'h0001);
    endtask : adr

    task wr(input logic [7:0] cmd, input int n, input logic [23:0] d);
        adr(1'b0);
        i2c_master_i.xfer(cmd, 1'b1, r, a);
        for (int i = 0; i < n; i++) begin
            i2c_master_i.xfer(d[8*i+:8], 1'b1, r, a);
        end
        i2c_master_i.stop;
    endtask : wr

    task rd(input logic [7:0] cmd, input logic direct, input int n, input logic [23:0] e);
        if (!direct) begin
            adr(1'b0);
            i2c_master_i.xfer(cmd, 1'b1, r, a);
        end
        adr(1'b1);
        for (int i = 0; i < n; i++) begin
            i2c_master_i.xfer(8'hFF, i == n - 1, r, a);
            check({8'h00, r}, {8'h00, e[8*i+:8]});
        end
        i2c_master_i.stop;
    endtask : rd

    // bounded wait, the flag settles within a few clocks
    task wait_int(input logic lvl);
        for (int k = 0; k < 16 && int_l !== lvl; k++) @(negedge clk);
        check({15'h0000, int_l}, {15'h0000, lvl});
    endtask : wait_int

    // expected input registers: outputs F00F drive 3C5A, pol0 inverts
    function automatic logic [15:0] exp_in();
        return ((16'hF00F & 16'h3C5A) | (16'h0FF0 & ext)) ^ 16'h00FF;
    endfunction : exp_in

    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(port_o, 16'hFFFF);
        check(port_oe, 16'h0000);
        check({15'h0000, int_l}, 16'h0001);
        rd(8'h06, 1'b0, 2, 24'h00FFFF);
        $display("test reset done");
        wr(8'h02, 3, 24'h5A3CA5);
        check(port_o, 16'h3C5A);
        wr(8'h07, 2, 24'h00F00F);
        check(port_oe, 16'hF00F);
        i2c_master_i.start;
        i2c_master_i.xfer({`SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
        i2c_master_i.stop;
        check({15'h0000, a}, 16'h0000);
        $display("test write done");
        rd(8'h03, 1'b0, 3, 24'h3C5A3C);
        rd(8'h00, 1'b1, 1, 24'h00005A);
        $display("test read done");
        wr(8'h04, 2, 24'h0000FF);
        ext = 16'hA5C3;
        wait_int(1'b0);
        ev = exp_in();
        rd(8'h00, 1'b0, 2, {8'h00, ev});
        check({15'h0000, int_l}, 16'h0001);
        wr(8'h00, 1, 24'h000055);
        rd(8'h00, 1'b0, 2, {8'h00, ev});
        $display("test input done");
        ext[4] = ~ext[4];
        wait_int(1'b0);
        ext[4] = ~ext[4];
        wait_int(1'b1);
        ext[9] = ~ext[9];
        wait_int(1'b0);
        ev = exp_in();
        rd(8'h01, 1'b0, 1, {16'h0000, ev[15:8]});
        check({15'h0000, int_l}, 16'h0001);
        ext[0] = ~ext[0];
        repeat (16) @(negedge clk);
        check({15'h0000, int_l}, 16'h0001);
        wr(8'h02, 1, 24'h00005B);
        repeat (16) @(negedge clk);
        check({15'h0000, int_l}, 16'h0001);
        $display("test interrupt done");
        rst = 1'b1;
        @(negedge clk);
        check(port_o, 16'hFFFF);
        check(port_oe, 16'h0000);
        rst = 1'b0;
        $display("test second reset done");
        print_verdict;
    end
endmodule : tb_io_expander
